/* pkg/pfs_pkg.sv */
package pfs_pkg;

	// ==========================================
	// register indices (byte address = 4 * index)
	localparam logic [31:0] IDX_PIN_MODE_CTRL  = 32'hfffff44a;
	localparam logic [31:0] IDX_FUNC_SELECT    = 32'hfffff46a;
	localparam logic [31:0] IDX_FUNC_EXT_SEL   = 32'hfffff70a;
	localparam logic [31:0] IDX_PORT5_OUT_TYPE = 32'h0ffffc6a;
	localparam logic [31:0] IDX_PORT5_DIR      = 32'hfffff42a;
	localparam logic [31:0] IDX_PORT5_LATCH    = 32'hfffff40a;
	localparam logic [31:0] IDX_ANALOG_LATCH_L = 32'hfffff40e;
	localparam logic [31:0] IDX_ANALOG_LATCH_H = 32'hfffff40f;
	localparam logic [31:0] IDX_ANALOG_DIR_L   = 32'hfffff42e;
	localparam logic [31:0] IDX_ANALOG_DIR_H   = 32'hfffff42f;
	localparam logic [31:0] IDX_PIN_STATUS     = 32'hfffff500;

	// ==========================================
	// widths and field positions
	localparam int P5_PINS      = 6;
	localparam int P7_PINS      = 10;
	localparam int P7_HIGH_PINS = 2;
	localparam int STAT_LVL_LSB = 0;
	localparam int STAT_BAD_LSB = 8;

	// ==========================================
	// reset values
	localparam logic [5:0] RST_PIN_MODE_CTRL  = 6'h00;
	localparam logic [5:0] RST_FUNC_SELECT    = 6'h00;
	localparam logic [5:0] RST_FUNC_EXT_SEL   = 6'h00;
	localparam logic [5:0] RST_PORT5_OUT_TYPE = 6'h00;
	localparam logic [5:0] RST_PORT5_DIR      = 6'h3f;
	localparam logic [5:0] RST_PORT5_LATCH    = 6'h00;
	localparam logic [7:0] RST_ANALOG_LATCH_L = 8'h00;
	localparam logic [1:0] RST_ANALOG_LATCH_H = 2'h0;
	localparam logic [7:0] RST_ANALOG_DIR_L   = 8'hff;
	localparam logic [1:0] RST_ANALOG_DIR_H   = 2'h3;

	// ==========================================
	// function select codes {ext, sel}
	typedef enum logic [1:0] {
		PFS_CODE_00 = 2'h0,
		PFS_CODE_01 = 2'h1,
		PFS_CODE_10 = 2'h2,
		PFS_CODE_11 = 2'h3
	} pfs_code_t;

	// prohibited-code masks, bit k set = code k prohibited
	localparam logic [3:0] BAD_PIN55 = 4'h4;
	localparam logic [3:0] BAD_PIN54 = 4'h4;
	localparam logic [3:0] BAD_PIN53 = 4'h0;
	localparam logic [3:0] BAD_LOW3  = 4'h1;

	function automatic logic pfs_hit(input logic [31:0] addr,
		input logic [31:0] idx);
		pfs_hit = (addr[31:2] == idx[29:0]) && (addr[1:0] == 2'h0);
	endfunction

endpackage

/* hw/pfs_pin_mux.sv */
`timescale 1ns/10ps
module pfs_pin_mux (
	// selection
	input  wire logic       mode_alt,
	input  wire logic [1:0] code,
	input  wire logic [3:0] bad_mask,
	input  wire logic       open_drain,
	// port mode
	input  wire logic       dir_in,
	input  wire logic       latch,
	// alternate drivers indexed by code
	input  wire logic [3:0] alt_data,
	input  wire logic [3:0] alt_en,
	// result
	output logic            pin_data,
	output logic            pin_drive,
	output logic [3:0]      func_active,
	output logic            bad_code
);
	logic legal;
	logic raw_data;
	logic raw_en;

	assign bad_code = mode_alt & bad_mask[code];
	assign legal    = ~bad_mask[code];
	// prohibited code: no driver, pin stays a plain input
	assign raw_en   = mode_alt ? (alt_en[code] & legal) : ~dir_in;
	assign raw_data = mode_alt ? alt_data[code] : latch;
	// one-hot of the alternate function in use
	assign func_active = (mode_alt & legal) ? (4'h1 << code) : 4'h0;
	// open-drain only pulls low, never drives high
	assign pin_drive = open_drain ? (raw_en & ~raw_data) : raw_en;
	assign pin_data  = open_drain ? 1'b0 : raw_data;

endmodule

/* hw/pfs_port_ctrl.sv */
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module pfs_port_ctrl (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// port 5 pins
	input  wire logic [5:0]  p5_pin_in,
	output logic      [5:0]  p5_pin_out,
	output logic      [5:0]  p5_pin_oe,
	// analog-shared port pins
	input  wire logic [9:0]  p7_pin_in,
	output logic      [9:0]  p7_pin_out,
	output logic      [9:0]  p7_pin_oe,
	// serial unit
	input  wire logic        serial_clock_line_out,
	input  wire logic        serial_clock_line_oe,
	output logic             serial_clock_line_in,
	input  wire logic        serial_out_line,
	output logic             serial_in_line,
	// key return, timer, realtime
	output logic      [5:0]  key_return_input,
	output logic      [3:0]  timer_capture_input,
	input  wire logic [3:0]  timer_output,
	input  wire logic [5:0]  realtime_output,
	// analog converter side
	output logic      [9:0]  analog_channel_input
);
	// ==========================================
	// registers
	logic [5:0] pin_mode_ctrl_r;
	logic [5:0] func_select_r;
	logic [5:0] func_ext_select_r;
	logic [5:0] output_type_r;
	logic [5:0] p5_dir_r;
	logic [5:0] p5_latch_r;
	logic [7:0] latch_low_r;
	logic [1:0] latch_high_r;
	logic [7:0] dir_low_r;
	logic [1:0] dir_high_r;
	logic       pready_r;
	logic       pslverr_r;
	logic [31:0] prdata_r;
	logic [5:0] p5_out_r;
	logic [5:0] p5_oe_r;
	logic [9:0] p7_out_r;
	logic [9:0] p7_oe_r;
	logic       sck_in_r;
	logic       sin_r;
	logic [5:0] key_r;
	logic [3:0] cap_r;
	logic [9:0] ana_r;

	// ==========================================
	// bus decode
	wire logic access   = psel & penable;
	wire logic take     = access & pready_r;
	wire logic wr_take  = take & pwrite & pstrb[0];
	wire logic h_pmc    = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_PIN_MODE_CTRL);
	wire logic h_pfc    = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_FUNC_SELECT);
	wire logic h_pfce   = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_FUNC_EXT_SEL);
	wire logic h_type   = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_PORT5_OUT_TYPE);
	wire logic h_p5dir  = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_PORT5_DIR);
	wire logic h_p5lat  = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_PORT5_LATCH);
	wire logic h_lat_l  = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_ANALOG_LATCH_L);
	wire logic h_lat_h  = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_ANALOG_LATCH_H);
	wire logic h_dir_l  = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_ANALOG_DIR_L);
	wire logic h_dir_h  = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_ANALOG_DIR_H);
	wire logic h_stat   = pfs_pkg::pfs_hit(paddr, pfs_pkg::IDX_PIN_STATUS);
	wire logic any_hit  = h_pmc | h_pfc | h_pfce | h_type | h_p5dir | h_p5lat
		| h_lat_l | h_lat_h | h_dir_l | h_dir_h | h_stat;

	// ==========================================
	// port 5 per-pin selection
	wire logic [5:0]  p5_data;
	wire logic [5:0]  p5_drive;
	wire logic [5:0]  p5_bad;
	wire logic [23:0] p5_act;
	wire logic [23:0] alt_d;
	wire logic [23:0] alt_e;
	wire logic [23:0] bad_m;

	// code order {11,10,01,00}; inputs carry no driver
	assign alt_d[3:0]   = {realtime_output[0], timer_output[1], 2'h0};
	assign alt_e[3:0]   = 4'hc;
	assign alt_d[7:4]   = {realtime_output[1], timer_output[2], 2'h0};
	assign alt_e[7:4]   = 4'hc;
	// timer 03 code drives the timer output although shown as input
	assign alt_d[11:8]  = {realtime_output[2], timer_output[3], 2'h0};
	assign alt_e[11:8]  = 4'hc;
	assign alt_d[15:12] = {realtime_output[3], timer_output[0], 2'h0};
	assign alt_e[15:12] = 4'hc;
	assign alt_d[19:16] = {realtime_output[4], 2'h0, serial_out_line};
	assign alt_e[19:16] = 4'h9;
	assign alt_d[23:20] = {realtime_output[5], 2'h0,
		serial_clock_line_out};
	assign alt_e[23:20] = {1'b1, 2'h0, serial_clock_line_oe};
	assign bad_m = {pfs_pkg::BAD_PIN55, pfs_pkg::BAD_PIN54,
		pfs_pkg::BAD_PIN53, pfs_pkg::BAD_LOW3, pfs_pkg::BAD_LOW3,
		pfs_pkg::BAD_LOW3};

	genvar gi;
	generate
		for (gi = 0; gi < pfs_pkg::P5_PINS; gi++) begin : g_pin
			pfs_pin_mux u_mux (
				.mode_alt    (pin_mode_ctrl_r[gi]),
				.code        ({func_ext_select_r[gi], func_select_r[gi]}),
				.bad_mask    (bad_m[gi*4 +: 4]),
				.open_drain  (output_type_r[gi]),
				.dir_in      (p5_dir_r[gi]),
				.latch       (p5_latch_r[gi]),
				.alt_data    (alt_d[gi*4 +: 4]),
				.alt_en      (alt_e[gi*4 +: 4]),
				.pin_data    (p5_data[gi]),
				.pin_drive   (p5_drive[gi]),
				.func_active (p5_act[gi*4 +: 4]),
				.bad_code    (p5_bad[gi])
			);
		end
	endgenerate

	// ==========================================
	// alternate inputs routed back to peripherals
	wire logic [5:0] key_nxt;
	wire logic [3:0] cap_nxt;
	wire logic       sck_nxt;
	wire logic       sin_nxt;

	// key-return and capture share code 01; the peer keeps one disabled
	genvar gk;
	generate
		for (gk = 0; gk < pfs_pkg::P5_PINS; gk++) begin : g_key
			assign key_nxt[gk] = p5_act[gk*4 + 1] ? p5_pin_in[gk] : 1'b1;
		end
	endgenerate
	assign cap_nxt[0] = p5_act[13] & p5_pin_in[3];
	assign cap_nxt[1] = p5_act[1]  & p5_pin_in[0];
	assign cap_nxt[2] = p5_act[5]  & p5_pin_in[1];
	assign cap_nxt[3] = p5_act[9]  & p5_pin_in[2];
	assign sin_nxt    = p5_act[12] & p5_pin_in[3];
	assign sck_nxt    = p5_act[20] ? p5_pin_in[5] : 1'b1;

	// ==========================================
	// analog-shared port
	wire logic [9:0] p7_latch = {latch_high_r, latch_low_r};
	wire logic [9:0] p7_dir   = {dir_high_r, dir_low_r};

	// ==========================================
	// read mux
	wire logic [31:0] stat_word = ({26'h0, p5_pin_in}
		<< pfs_pkg::STAT_LVL_LSB) | ({26'h0, p5_bad}
		<< pfs_pkg::STAT_BAD_LSB);
	wire logic [31:0] rd_word =
		h_pmc   ? {26'h0, pin_mode_ctrl_r} :
		h_pfc   ? {26'h0, func_select_r} :
		h_pfce  ? {26'h0, func_ext_select_r} :
		h_type  ? {26'h0, output_type_r} :
		h_p5dir ? {26'h0, p5_dir_r} :
		h_p5lat ? {26'h0, p5_latch_r} :
		h_lat_l ? {24'h0, latch_low_r} :
		h_lat_h ? {30'h0, latch_high_r} :
		h_dir_l ? {24'h0, dir_low_r} :
		h_dir_h ? {24'h0, 6'h3f, dir_high_r} :
		h_stat  ? stat_word : 32'h0;

	// ==========================================
	// bus handshake: one wait state, then answer
	always_ff @(posedge clock) begin
		if (rst) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= access & ~pready_r;
			pslverr_r <= access & ~pready_r & ~any_hit;
			prdata_r  <= (access & ~pready_r & ~pwrite) ? rd_word : 32'h0;
		end
	end

	// ==========================================
	// register writes
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_mode_ctrl_r   <= pfs_pkg::RST_PIN_MODE_CTRL;
			func_select_r     <= pfs_pkg::RST_FUNC_SELECT;
			func_ext_select_r <= pfs_pkg::RST_FUNC_EXT_SEL;
			output_type_r     <= pfs_pkg::RST_PORT5_OUT_TYPE;
			p5_dir_r          <= pfs_pkg::RST_PORT5_DIR;
			p5_latch_r        <= pfs_pkg::RST_PORT5_LATCH;
		end else if (wr_take) begin
			if (h_pmc)
				pin_mode_ctrl_r <= pwdata[5:0];
			if (h_pfc)
				func_select_r <= pwdata[5:0];
			if (h_pfce)
				func_ext_select_r <= pwdata[5:0];
			// bits 6-7 not stored, read back as zero
			if (h_type)
				output_type_r <= pwdata[5:0];
			if (h_p5dir)
				p5_dir_r <= pwdata[5:0];
			if (h_p5lat)
				p5_latch_r <= pwdata[5:0];
		end
	end

	// each byte only through its own word
	always_ff @(posedge clock) begin
		if (rst) begin
			latch_low_r  <= pfs_pkg::RST_ANALOG_LATCH_L;
			latch_high_r <= pfs_pkg::RST_ANALOG_LATCH_H;
			dir_low_r    <= pfs_pkg::RST_ANALOG_DIR_L;
			dir_high_r   <= pfs_pkg::RST_ANALOG_DIR_H;
		end else if (wr_take) begin
			if (h_lat_l)
				latch_low_r <= pwdata[7:0];
			if (h_lat_h)
				latch_high_r <= pwdata[1:0];
			if (h_dir_l)
				dir_low_r <= pwdata[7:0];
			if (h_dir_h)
				dir_high_r <= pwdata[1:0];
		end
	end

	// ==========================================
	// pin and peripheral outputs, all registered
	always_ff @(posedge clock) begin
		if (rst) begin
			p5_out_r <= 6'h0;
			p5_oe_r  <= 6'h0;
			p7_out_r <= 10'h0;
			p7_oe_r  <= 10'h0;
			sck_in_r <= 1'b1;
			sin_r    <= 1'b0;
			key_r    <= 6'h3f;
			cap_r    <= 4'h0;
			ana_r    <= 10'h0;
		end else begin
			p5_out_r <= p5_data;
			p5_oe_r  <= p5_drive;
			p7_out_r <= p7_latch;
			p7_oe_r  <= ~p7_dir;
			sck_in_r <= sck_nxt;
			sin_r    <= sin_nxt;
			key_r    <= key_nxt;
			cap_r    <= cap_nxt;
			// channel n sees pin n; valid once set to input
			ana_r    <= p7_pin_in & p7_dir;
		end
	end

	assign prdata               = prdata_r;
	assign pready               = pready_r;
	assign pslverr              = pslverr_r;
	assign p5_pin_out           = p5_out_r;
	assign p5_pin_oe            = p5_oe_r;
	assign p7_pin_out           = p7_out_r;
	assign p7_pin_oe            = p7_oe_r;
	assign serial_clock_line_in = sck_in_r;
	assign serial_in_line       = sin_r;
	assign key_return_input     = key_r;
	assign timer_capture_input  = cap_r;
	assign analog_channel_input = ana_r;

endmodule

/* tb/pfs_port_ctrl_properties.sv */
`timescale 1ns/10ps
module pfs_port_ctrl_chk (
	// clock, reset, bus
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic [5:0]  p5_pin_in,
	input wire logic [9:0]  p7_pin_in,
	input wire logic [9:0]  p7_pin_out,
	input wire logic [9:0]  p7_pin_oe,
	// peripheral side
	input wire logic        serial_clock_line_in,
	input wire logic        serial_in_line,
	input wire logic [5:0]  key_return_input,
	input wire logic [3:0]  timer_capture_input,
	input wire logic [9:0]  analog_channel_input
);
	wire wr_done = psel && penable && pready && pwrite;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// ==========
	// bus handshake
	a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("ready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_idle: assert property (!pready || pwrite |-> prdata == 32'h0)
		else $error("read data outside read answer");
	// ==========
	// pin relations
	a_chan_dir: assert property (!$past(rst) |-> analog_channel_input ==
		($past(p7_pin_in) & ~p7_pin_oe)) else $error("channel not gated by dir");
	a_p7_write: assert property (!$past(rst) && $changed({p7_pin_out, p7_pin_oe})
		|-> $past(wr_done, 2)) else $error("analog pins moved without write");
	a_serial_in: assert property (serial_in_line |-> $past(p5_pin_in[3]))
		else $error("serial input without pin level");
	a_sck_in: assert property (!serial_clock_line_in |-> !$past(p5_pin_in[5]))
		else $error("clock input low with pin high");
	a_key_level: assert property (($past(p5_pin_in) & ~key_return_input) == 6'h0)
		else $error("key low with pin high");
	a_cap_key: assert property ((timer_capture_input & ~{key_return_input[2:0],
		key_return_input[3]}) == 4'h0) else $error("capture and key disagree");
	a_cap_serial: assert property (!(timer_capture_input[0] && serial_in_line))
		else $error("two input functions on one pin");

	c_write: cover property (wr_done);
	c_error: cover property (pslverr);
	c_capture: cover property (timer_capture_input != 4'h0);
endmodule

bind pfs_port_ctrl pfs_port_ctrl_chk u_chk (
	.clock(clock), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.p5_pin_in(p5_pin_in), .p7_pin_in(p7_pin_in), .p7_pin_out(p7_pin_out),
	.p7_pin_oe(p7_pin_oe), .serial_clock_line_in(serial_clock_line_in),
	.serial_in_line(serial_in_line), .key_return_input(key_return_input),
	.timer_capture_input(timer_capture_input),
	.analog_channel_input(analog_channel_input)
);

/* tb/pfs_board_model.sv */
`timescale 1ns/10ps
module pfs_board_model (
	// device drivers
	input wire logic [5:0] p5_pin_out,
	input wire logic [5:0] p5_pin_oe,
	input wire logic [9:0] p7_pin_out,
	input wire logic [9:0] p7_pin_oe,
	// board level on released lines
	input wire logic [5:0] p5_ext,
	input wire logic [9:0] p7_ext,
	// levels back to the device
	output logic     [5:0] p5_pin_in,
	output logic     [9:0] p7_pin_in
);
	// released line shows the board level, never the last driven value
	assign p5_pin_in = (p5_pin_oe & p5_pin_out) | (~p5_pin_oe & p5_ext);
	assign p7_pin_in = (p7_pin_oe & p7_pin_out) | (~p7_pin_oe & p7_ext);
endmodule

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
	// ==========
	// signals
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic        pready, pslverr, e, sck_i, si;
	logic [5:0]  p5_in, p5_out, p5_oe, key;
	logic [5:0]  p5_ext = 6'h0b;
	logic [5:0]  rt = 6'h0;
	logic [9:0]  p7_in, p7_out, p7_oe, chan;
	logic [9:0]  p7_ext = 10'h2c3;
	logic        sck_o = 1'b0;
	logic        sck_e = 1'b0;
	logic        so = 1'b0;
	logic [3:0]  cap;
	logic [3:0]  tmr = 4'h0;
	int          err_total = 0;
	int          tests_run = 0;
	int          cyc = 0;
	// {bad flags, oe, driven out, key, capture, serial in, clock in}
	logic [31:0] alt_x [4] = '{32'h07c10fc2, 32'h000002dd,
		32'h303cafc1, 32'h00feafc1};

	pfs_port_ctrl u_dut (
		.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.p5_pin_in(p5_in), .p5_pin_out(p5_out), .p5_pin_oe(p5_oe),
		.p7_pin_in(p7_in), .p7_pin_out(p7_out), .p7_pin_oe(p7_oe),
		.serial_clock_line_out(sck_o), .serial_clock_line_oe(sck_e),
		.serial_clock_line_in(sck_i), .serial_out_line(so),
		.serial_in_line(si), .key_return_input(key),
		.timer_capture_input(cap), .timer_output(tmr),
		.realtime_output(rt), .analog_channel_input(chan)
	);
	pfs_board_model u_board (
		.p5_pin_out(p5_out), .p5_pin_oe(p5_oe), .p7_pin_out(p7_out),
		.p7_pin_oe(p7_oe), .p5_ext(p5_ext), .p7_ext(p7_ext),
		.p5_pin_in(p5_in), .p7_pin_in(p7_in)
	);

	always #12.5 clock = ~clock;

	// ==========
	// tasks
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] x, y);
		tests_run++;
		if (y !== x) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, x, y);
		end
	endtask

	// one transfer, released after the ready edge, one idle cycle after
	task automatic bus(input logic w, input logic [31:0] idx, d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx[29:0], 2'h0};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		// a wait that runs out is a failure, not a silent pass
		if (pready !== 1'b1) begin
			err_total++;
			$display("MISMATCH bus ready expected 1 seen %b", pready);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [31:0] idx, x, input logic xe);
		bus(1'b0, idx, 32'h0);
		chk("read data", x, q);
		chk("slave error", {31'h0, xe}, {31'h0, e});
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			finish_test;
		end
	end

	// ==========
	// sequence
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(pfs_pkg::IDX_PORT5_OUT_TYPE, 32'h0, 1'b0);
		rd(pfs_pkg::IDX_ANALOG_LATCH_H, 32'h0, 1'b0);
		// bits 6-7 kept zero; bit 8 lies outside the register
		bus(1'b1, pfs_pkg::IDX_PORT5_OUT_TYPE, 32'h13f);
		rd(pfs_pkg::IDX_PORT5_OUT_TYPE, 32'h3f, 1'b0);
		bus(1'b1, pfs_pkg::IDX_PORT5_OUT_TYPE, 32'h0);
		rd(32'hfffff404, 32'h0, 1'b1);
		$display("test registers done");
		// upper bytes of each word must not reach the other latch half
		// no conversion runs on this bench, latch access is free
		bus(1'b1, pfs_pkg::IDX_ANALOG_LATCH_L, 32'h00a5);
		bus(1'b1, pfs_pkg::IDX_ANALOG_LATCH_H, 32'h01ff);
		rd(pfs_pkg::IDX_ANALOG_LATCH_L, 32'ha5, 1'b0);
		rd(pfs_pkg::IDX_ANALOG_LATCH_H, 32'h3, 1'b0);
		bus(1'b1, pfs_pkg::IDX_ANALOG_DIR_L, 32'hf0);
		bus(1'b1, pfs_pkg::IDX_ANALOG_DIR_H, 32'h3);
		repeat (2) @(posedge clock);
		chk("p7 pins", 32'h3a503ec0,
			{2'h0, p7_out, p7_oe, chan});
		$display("test analog port done");
		bus(1'b1, pfs_pkg::IDX_PORT5_DIR, 32'h0);
		bus(1'b1, pfs_pkg::IDX_PORT5_LATCH, 32'h2d);
		bus(1'b1, pfs_pkg::IDX_FUNC_SELECT, 32'h3f);
		repeat (2) @(posedge clock);
		chk("port mode", 32'h3f2d3f,
			{10'h0, p5_oe, 2'h0, p5_out, 2'h0, key});
		tmr <= 4'h5;
		rt <= 6'h2a;
		so <= 1'b1;
		sck_e <= 1'b1;
		// key mask and timer edge selects stay cleared outside the block
		bus(1'b1, pfs_pkg::IDX_PIN_MODE_CTRL, 32'h3f);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, pfs_pkg::IDX_FUNC_SELECT, c[0] ? 32'h3f : 32'h0);
			bus(1'b1, pfs_pkg::IDX_FUNC_EXT_SEL, c[1] ? 32'h3f : 32'h0);
			bus(1'b0, pfs_pkg::IDX_PIN_STATUS, 32'h0);
			chk("alt pins", alt_x[c], {2'h0, q[13:8], p5_oe, p5_out & p5_oe,
				key, cap, si, sck_i});
		end
		$display("test alternate codes done");
		bus(1'b1, pfs_pkg::IDX_PORT5_OUT_TYPE, 32'h3f);
		repeat (2) @(posedge clock);
		chk("open drain", 32'h1500, {16'h0, 2'h0, p5_oe, 2'h0, p5_out});
		$display("test open drain done");
		finish_test;
	end
endmodule
